//--- design/fprf_map.vh
`ifndef FPRF_MAP_VH
`define FPRF_MAP_VH

// Register indices on the plain register port
`define FPRF_ADDR_W        4
`define FPRF_REG_CTRL      4'h0
`define FPRF_REG_STATUS    4'h1
`define FPRF_REG_IRQ_STAT  4'h2
`define FPRF_REG_IRQ_MASK  4'h3
`define FPRF_REG_VECTOR    4'h4

// Control register fields
`define FPRF_CTRL_RST_EN   0
`define FPRF_CTRL_ABT_EN   1
`define FPRF_CTRL_BRDFL    2
`define FPRF_CTRL_SFINH    3
`define FPRF_CTRL_RESET    8'h04

// Status register fields
`define FPRF_ST_SYSCON     0
`define FPRF_ST_FAIL       1
`define FPRF_ST_ABT_PEND   2
`define FPRF_ST_RST_LVL    3
`define FPRF_ST_ABT_LVL    4
`define FPRF_ST_WDOG       5

// Interrupt status fields
`define FPRF_IRQ_ABORT     0
`define FPRF_IRQ_RESET     1
`define FPRF_IRQ_WDOG      2
`define FPRF_IRQ_W         3

// Vector reset value, arbitrary
`define FPRF_VECTOR_RESET  8'h40

// Debounce time and reset pulse length
`define FPRF_CLK_MHZ       50
`define FPRF_DEB_US        10
`define FPRF_DEB_CYC       16'd500
`define FPRF_RSTO_CYC      16'h00ff
`define FPRF_LEVEL7        3'h7

`endif

//--- design/fprf_debounce.v
`timescale 1ns/10ps
module fprf_debounce
#(
	parameter CNT_W = 16,
	parameter [15:0] STABLE = 16'd500
)
(
	// Clock and reset
	input  wire       i_clk_sys,
	input  wire       i_nrst,
	// Raw level, already synchronised
	input  wire       i_level,
	// Filtered level
	output reg        o_level
);

	reg [CNT_W-1:0] count;

	// A change is taken only after it has held STABLE cycles; bounces restart the count
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			count   <= {CNT_W{1'b0}};
			o_level <= 1'b0;
		end
		else if (i_level == o_level)
			count <= {CNT_W{1'b0}};
		else if (count >= STABLE - 16'd1)
		begin
			o_level <= i_level;
			count   <= {CNT_W{1'b0}};
		end
		else
			count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
	end

endmodule // fprf_debounce

//--- design/fprf_front_panel.v
// How it works
// - The strap is active when fitted and the board is system controller only while it is active.
// - As system controller the board starts the bus grant daisy chain.
// - An enabled reset press drives local reset, and backplane system reset too when system controller.
// - The reset switch is debounced and gives its reset output only while enabled.
// - Software enables or disables the reset switch, and a disabled switch causes no reset.
// - The remote reset input acts exactly like the front reset switch, either one alone suffices.
// - The abort switch is debounced and, when enabled, raises a level 7 interrupt.
// - An acknowledge cycle for the abort interrupt is answered with a status/ID vector.
// - Software enables the abort switch, and a disabled switch gives no interrupt.
// - The fail indicator lights while the board-fail flag is set or the watchdog time-out input is high.
// - SYSFAIL is driven while the fail condition holds and the inhibit bit is clear.
// - The status indicator lights while the processor status pin is low.
// - The board-fail flag is set at reset, stays set until cleared, and can be set again by software.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "fprf_map.vh"
module fprf_front_panel
#(
	parameter [15:0] DEB_CYC  = `FPRF_DEB_CYC,
	parameter [15:0] RSTO_CYC = `FPRF_RSTO_CYC
)
(
	// Clock and reset
	input  wire       i_clk_sys,
	input  wire       i_nrst,
	// Register port
	input  wire [3:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	output reg        o_irq,
	// Pins, active low where named so
	input  wire       i_syscon_strap_n,
	input  wire       i_front_reset_switch_n,
	input  wire       i_remote_reset_input_n,
	input  wire       i_front_abort_switch_n,
	input  wire       i_wdog_timeout,
	input  wire       i_cpu_status_n,
	// Interrupt acknowledge from the processor
	input  wire       i_iack,
	input  wire [2:0] i_iack_level,
	output reg        o_iack_ack,
	output reg  [7:0] o_iack_vector,
	output reg        o_ipl7_n,
	// Resets and backplane
	output reg        o_local_reset_n,
	output reg        o_sysreset_oe,
	output reg        o_sysfail_oe,
	output reg        o_bus_grant_out_n,
	// Indicators
	output reg        o_fail_indicator,
	output reg        o_status_indicator,
	output reg        o_syscon_indicator
);

	// Two-stage synchronisers for all pins
	// Reset to idle pin levels so no false press or watchdog edge follows reset
	localparam [5:0] SYNC_IDLE = 6'h2f;

	reg  [5:0] sync1;
	reg  [5:0] sync2;
	wire [5:0] pins_raw;
	wire [5:0] pins_n;

	assign pins_raw = {i_cpu_status_n, i_wdog_timeout, i_front_abort_switch_n,
		i_remote_reset_input_n, i_front_reset_switch_n, i_syscon_strap_n};

	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
		end
		else
		begin
			sync1 <= pins_raw;
			sync2 <= sync1;
		end
	end

	assign pins_n = sync2;

	wire strap_fitted  = ~pins_n[0];
	wire rst_raw       = ~pins_n[1] | ~pins_n[2];
	wire abt_raw       = ~pins_n[3];
	wire wdog_level    = pins_n[4];
	wire cpu_status_lo = ~pins_n[5];

	// Debounce reset and abort levels
	wire rst_deb;
	wire abt_deb;

	fprf_debounce #(.CNT_W(16), .STABLE(DEB_CYC)) u_deb_rst
	(
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_level   (rst_raw),
		.o_level   (rst_deb)
	);

	fprf_debounce #(.CNT_W(16), .STABLE(DEB_CYC)) u_deb_abt
	(
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_level   (abt_raw),
		.o_level   (abt_deb)
	);

	// Control and interrupt registers
	reg  [7:0] ctrl;
	reg  [7:0] vector;
	reg  [2:0] irq_stat;
	reg  [2:0] irq_mask;
	reg        syscon;
	reg        rst_deb_q;
	reg        abt_deb_q;
	reg        wdog_q;
	reg        abt_pend;
	reg [15:0] rsto_cnt;
	reg        rsto_act;

	wire rst_en     = ctrl[`FPRF_CTRL_RST_EN];
	wire abt_en     = ctrl[`FPRF_CTRL_ABT_EN];
	wire board_fail_flag = ctrl[`FPRF_CTRL_BRDFL];
	wire sf_inhibit = ctrl[`FPRF_CTRL_SFINH];

	// Rising edge of a filtered level, or of the unfiltered watchdog level, against its one-cycle history
	function rise;
		input now_lvl;
		input old_lvl;
		begin
			rise = now_lvl & ~old_lvl;
		end
	endfunction

	wire rst_press  = rise(rst_deb, rst_deb_q);
	wire abt_press  = rise(abt_deb, abt_deb_q);
	wire wdog_rise  = rise(wdog_level, wdog_q);
	wire fail_cond  = board_fail_flag | wdog_level;

	// Register select, shared by all write decodes
	function reg_hit;
		input [3:0] a;
		input [3:0] idx;
		begin
			reg_hit = (a == idx);
		end
	endfunction

	wire wr_ctrl    = i_wr && reg_hit(i_addr, `FPRF_REG_CTRL);
	wire wr_istat   = i_wr && reg_hit(i_addr, `FPRF_REG_IRQ_STAT);
	wire wr_imask   = i_wr && reg_hit(i_addr, `FPRF_REG_IRQ_MASK);
	wire wr_vector  = i_wr && reg_hit(i_addr, `FPRF_REG_VECTOR);
	wire ack_abort  = i_iack && (i_iack_level == `FPRF_LEVEL7) && abt_pend;

	wire [2:0] irq_set = {wdog_rise, rst_press & rst_en, abt_press & abt_en};

	function [7:0] read_mux;
		input [3:0] a;
		begin
			case (a)
				`FPRF_REG_CTRL:     read_mux = ctrl;
				`FPRF_REG_STATUS:   read_mux = {2'h0, wdog_level, abt_deb, rst_deb, abt_pend, fail_cond, syscon};
				`FPRF_REG_IRQ_STAT: read_mux = {5'h00, irq_stat};
				`FPRF_REG_IRQ_MASK: read_mux = {5'h00, irq_mask};
				`FPRF_REG_VECTOR:   read_mux = vector;
				default:            read_mux = 8'h00;
			endcase
		end
	endfunction

	// Software registers
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ctrl     <= `FPRF_CTRL_RESET;
			vector   <= `FPRF_VECTOR_RESET;
			irq_mask <= 3'h0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= i_wdata;
			if (wr_imask)
				irq_mask <= i_wdata[2:0];
			if (wr_vector)
				vector <= i_wdata;
		end
	end

	// One-cycle history for the edge detectors
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rst_deb_q <= 1'b0;
			abt_deb_q <= 1'b0;
			wdog_q    <= 1'b0;
		end
		else
		begin
			rst_deb_q <= rst_deb;
			abt_deb_q <= abt_deb;
			wdog_q    <= wdog_level;
		end
	end

	// Strap followed, not latched: pulling the jumper gives up the controller role at once
	// Reads not fitted until the synchroniser has filled after reset
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			syscon <= 1'b0;
		else
			syscon <= strap_fitted;
	end

	// Sticky events; a new event wins over a write-one-to-clear in the same cycle
	wire [2:0] irq_clr = wr_istat ? i_wdata[2:0] : 3'h0;

	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			irq_stat <= 3'h0;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
	end

	// Abort request held until acknowledged, dropped when software disables abort
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			abt_pend <= 1'b0;
		else if (abt_press && abt_en)
			abt_pend <= 1'b1;
		else if (ack_abort || !abt_en)
			abt_pend <= 1'b0;
	end

	// Reset output pulse; a short press is stretched so everything behind it sees a full reset
	localparam RSTO_IDLE  = 1'b0;
	localparam RSTO_PULSE = 1'b1;

	reg        rsto_state;
	reg        next_rsto_state;
	reg [15:0] next_rsto_cnt;
	wire       rst_go = rst_press & rst_en;

	always @*
	begin
		next_rsto_state = rsto_state;
		next_rsto_cnt   = rsto_cnt;
		case (rsto_state)
			RSTO_IDLE:
			begin
				if (rst_go)
				begin
					next_rsto_state = RSTO_PULSE;
					next_rsto_cnt   = RSTO_CYC;
				end
			end
			RSTO_PULSE:
			begin
				// A press during the pulse restarts it rather than being lost
				if (rst_go)
					next_rsto_cnt = RSTO_CYC;
				else if (rsto_cnt != 16'h0000)
					next_rsto_cnt = rsto_cnt - 16'h0001;
				else
					next_rsto_state = RSTO_IDLE;
			end
			default:
			begin
				next_rsto_state = RSTO_IDLE;
				next_rsto_cnt   = 16'h0000;
			end
		endcase
	end

	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rsto_state <= RSTO_IDLE;
			rsto_cnt   <= 16'h0000;
			rsto_act   <= 1'b0;
		end
		else
		begin
			rsto_state <= next_rsto_state;
			rsto_cnt   <= next_rsto_cnt;
			rsto_act   <= (next_rsto_state == RSTO_PULSE);
		end
	end

	// Read data stand only in the cycle after the strobe, zero otherwise
	// so a stray sample of the bus never shows a stale register
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			o_rdata <= 8'h00;
		else
			o_rdata <= i_rd ? read_mux(i_addr) : 8'h00;
	end

	// Registered outputs
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_irq              <= 1'b0;
			o_iack_ack         <= 1'b0;
			o_iack_vector      <= 8'h00;
			o_ipl7_n           <= 1'b1;
			o_local_reset_n    <= 1'b1;
			o_sysreset_oe      <= 1'b0;
			o_sysfail_oe       <= 1'b0;
			o_bus_grant_out_n  <= 1'b1;
			o_fail_indicator   <= 1'b0;
			o_status_indicator <= 1'b0;
			o_syscon_indicator <= 1'b0;
		end
		else
		begin
			o_irq              <= |(irq_stat & irq_mask);
			o_iack_ack         <= ack_abort;
			o_iack_vector      <= ack_abort ? vector : 8'h00;
			o_ipl7_n           <= ~(abt_pend & ~ack_abort);
			o_local_reset_n    <= ~rsto_act;
			o_sysreset_oe      <= rsto_act & syscon;
			o_sysfail_oe       <= fail_cond & ~sf_inhibit;
			o_bus_grant_out_n  <= ~syscon;
			o_fail_indicator   <= fail_cond;
			o_status_indicator <= cpu_status_lo;
			o_syscon_indicator <= syscon;
		end
	end

endmodule // fprf_front_panel

//--- dv/fprf_cpu_model.sv
`timescale 1ns/10ps
module fprf_cpu_model (
	// Bench command and clock
	input  wire logic       i_clk_sys,
	input  wire logic       i_go,
	input  wire logic [2:0] i_lvl,
	// Acknowledge handshake
	input  wire logic       i_ack,
	output logic            o_iack  = 1'b0,
	output logic [2:0]      o_level = 3'h0
);
	// Request held until answered; a released level bus toggles every cycle, showing the inverse and the old value in turn
	always @(posedge i_clk_sys)
	begin
		if (i_go && !(o_iack && i_ack))
		begin
			o_iack  <= 1'b1;
			o_level <= i_lvl;
		end
		else
		begin
			o_iack  <= 1'b0;
			o_level <= ~o_level;
		end
	end
endmodule // fprf_cpu_model

//--- dv/fprf_asserts.sv
`timescale 1ns/10ps
module fprf_asserts (
	// Clock, reset and pins
	input wire logic       i_clk_sys,
	input wire logic       i_nrst,
	input wire logic       i_iack,
	input wire logic [2:0] i_iack_level,
	input wire logic       i_cpu_status_n,
	input wire logic       i_wdog_timeout,
	// Outputs
	input wire logic       o_iack_ack,
	input wire logic [7:0] o_iack_vector,
	input wire logic       o_ipl7_n,
	input wire logic       o_local_reset_n,
	input wire logic       o_sysreset_oe,
	input wire logic       o_sysfail_oe,
	input wire logic       o_bus_grant_out_n,
	input wire logic       o_fail_indicator,
	input wire logic       o_status_indicator,
	input wire logic       o_syscon_indicator
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	sequence s_abort_req;
		i_iack && i_iack_level == 3'h7 && !o_ipl7_n;
	endsequence
	a_abort_ack: assert property (s_abort_req |=> o_iack_ack && o_ipl7_n)
		else $error("abort ack missing");
	a_ack_cause: assert property (o_iack_ack |-> $past(i_iack && i_iack_level == 3'h7))
		else $error("ack without request");
	a_vector_idle: assert property (!o_iack_ack |-> o_iack_vector == 8'h00)
		else $error("vector without ack");
	a_sysrst_scon: assert property (o_sysreset_oe |-> !o_local_reset_n && o_syscon_indicator)
		else $error("bad system reset");
	a_grant_scon: assert property (o_bus_grant_out_n == !o_syscon_indicator)
		else $error("grant chain mismatch");
	a_sysfail_gate: assert property (o_sysfail_oe |-> o_fail_indicator)
		else $error("sysfail without fail");
	a_status_led: assert property ($stable(i_cpu_status_n)[*5] |-> o_status_indicator == !i_cpu_status_n)
		else $error("status lamp wrong");
	a_wdog_fail: assert property (i_wdog_timeout[*5] |-> o_fail_indicator)
		else $error("watchdog lamp off");
endmodule // fprf_asserts

//--- dv/fprf_front_panel_tb.sv
`timescale 1ns/10ps
`include "fprf_map.vh"
module fprf_front_panel_tb;
	logic       i_clk_sys = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic       i_syscon_strap_n = 1'b0, i_cpu_status_n = 1'b1, i_wdog_timeout = 1'b0;
	logic       i_front_reset_switch_n = 1'b1, i_remote_reset_input_n = 1'b1, i_front_abort_switch_n = 1'b1;
	logic [2:0] lvl = 3'h0;
	wire        i_iack, o_irq, o_iack_ack, o_ipl7_n, o_local_reset_n, o_sysreset_oe, o_sysfail_oe;
	wire        o_bus_grant_out_n, o_fail_indicator, o_status_indicator, o_syscon_indicator;
	wire  [2:0] i_iack_level;
	wire  [7:0] o_rdata, o_iack_vector;
	int         fails = 0, n_compared = 0, cycles = 0;
	fprf_front_panel #(.DEB_CYC(16'd4), .RSTO_CYC(16'd4)) dut (.*);
	fprf_cpu_model u_cpu (.i_clk_sys(i_clk_sys), .i_go(go), .i_lvl(lvl), .i_ack(o_iack_ack),
		.o_iack(i_iack), .o_level(i_iack_level));
	initial
	begin
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		cyc(1);
		i_wr    <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		i_addr <= a;
		i_rd   <= 1'b1;
		cyc(1);
		i_rd   <= 1'b0;
		#1 chk(o_rdata, e);
		cyc(1);
	endtask
	task automatic iack(input logic [2:0] l, input logic [7:0] e);
		logic [7:0] v;
		v = 8'h00;
		go  <= 1'b1;
		lvl <= l;
		repeat (6)
		begin
			cyc(1);
			#1 if (o_iack_ack === 1'b1) v = o_iack_vector;
		end
		go <= 1'b0;
		cyc(1);
		chk(v, e);
	endtask
	// Polls one cycle late at worst, still well inside the pulse
	task automatic await_rst();
		for (int k = 0; k < 16 && o_local_reset_n !== 1'b0; k++)
			cyc(1);
		#1 chk({o_local_reset_n, o_sysreset_oe}, 8'h01);
	endtask
	task automatic t_boot();
		#1 chk({o_fail_indicator, o_sysfail_oe, o_syscon_indicator, o_bus_grant_out_n}, 8'h0e);
		rd(`FPRF_REG_CTRL, `FPRF_CTRL_RESET);
		rd(`FPRF_REG_VECTOR, `FPRF_VECTOR_RESET);
		rd(4'hf, 8'h00);
	endtask
	task automatic t_fail();
		wr(`FPRF_REG_CTRL, 8'h0c);
		cyc(2);
		#1 chk({o_fail_indicator, o_sysfail_oe}, 8'h02);
		wr(`FPRF_REG_CTRL, 8'h00);
		cyc(2);
		#1 chk({o_fail_indicator, o_sysfail_oe}, 8'h00);
		i_wdog_timeout <= 1'b1;
		cyc(6);
		#1 chk({o_fail_indicator, o_sysfail_oe}, 8'h03);
		i_wdog_timeout <= 1'b0;
		wr(`FPRF_REG_CTRL, 8'h04);
		cyc(2);
		#1 chk(o_fail_indicator, 8'h01);
		i_cpu_status_n <= 1'b0;
		cyc(5);
		#1 chk(o_status_indicator, 8'h01);
		i_cpu_status_n <= 1'b1;
	endtask
	task automatic t_abort();
		wr(`FPRF_REG_IRQ_MASK, 8'h01);
		i_front_abort_switch_n <= 1'b0;
		cyc(14);
		#1 chk({o_ipl7_n, o_irq}, 8'h02);
		i_front_abort_switch_n <= 1'b1;
		cyc(14);
		wr(`FPRF_REG_VECTOR, 8'h5a);
		wr(`FPRF_REG_CTRL, 8'h06);
		i_front_abort_switch_n <= 1'b0;
		cyc(14);
		#1 chk({o_ipl7_n, o_irq}, 8'h01);
		i_front_abort_switch_n <= 1'b1;
		iack(3'h6, 8'h00);
		iack(3'h7, 8'h5a);
		wr(`FPRF_REG_IRQ_STAT, 8'h07);
		cyc(2);
		#1 chk({o_ipl7_n, o_irq}, 8'h02);
	endtask
	task automatic t_reset();
		i_remote_reset_input_n <= 1'b0;
		cyc(14);
		#1 chk(o_local_reset_n, 8'h01);
		i_remote_reset_input_n <= 1'b1;
		wr(`FPRF_REG_CTRL, 8'h05);
		cyc(14);
		i_front_reset_switch_n <= 1'b0;
		cyc(2);
		i_front_reset_switch_n <= 1'b1;
		cyc(14);
		#1 chk(o_local_reset_n, 8'h01);
		i_front_reset_switch_n <= 1'b0;
		await_rst();
		i_front_reset_switch_n <= 1'b1;
		cyc(20);
		i_remote_reset_input_n <= 1'b0;
		await_rst();
		i_remote_reset_input_n <= 1'b1;
	endtask
	task automatic t_strap();
		i_syscon_strap_n <= 1'b1;
		cyc(20);
		#1 chk({o_syscon_indicator, o_bus_grant_out_n}, 8'h01);
		i_remote_reset_input_n <= 1'b0;
		for (int k = 0; k < 16 && o_local_reset_n !== 1'b0; k++)
			cyc(1);
		#1 chk({o_local_reset_n, o_sysreset_oe}, 8'h00);
		i_remote_reset_input_n <= 1'b1;
	endtask
	initial
	begin
		cyc(20);
		i_nrst <= 1'b1;
		cyc(4);
		t_boot();
		t_fail();
		t_abort();
		t_reset();
		t_strap();
		wrap_up();
	end
endmodule // fprf_front_panel_tb
bind fprf_front_panel fprf_asserts u_asrt (.*);
